/* pkg/itam_pkg.sv */
// Types of the ten-bit multi-address target matcher
package itam_pkg;
    typedef enum logic [2:0] {
        ITAM_IDLE,
        ITAM_ADDR1,
        ITAM_ACK1,
        ITAM_ADDR2,
        ITAM_ACK2,
        ITAM_DATA,
        ITAM_DACK,
        ITAM_IGNORE
    } itam_state_e;
endpackage

/* pkg/itam_regs.svh */
// Constants of the ten-bit multi-address target matcher
`ifndef ITAM_REGS_SVH
`define ITAM_REGS_SVH
`define ITAM_PREFIX 5'h1e
`define ITAM_BYTE_BITS 4'h8
`define ITAM_CNT_ZERO 4'h0
`define ITAM_CNT_ONE 4'h1
`define ITAM_BYTE_ZERO 8'h00
`define ITAM_HI_ZERO 2'h0
`define ITAM_SEL_ZERO 2'h0
`define ITAM_HI_MASK 10'h300
`define ITAM_FULL_MASK 10'h3ff
`endif

/* rtl/itam_top.sv */
// I2C target recognising up to four own ten-bit addresses
// Notes on behaviour
// [RULE1] Holds up to four own ten-bit addresses; answers writes to any enabled one.
// [RULE2] First byte is 11110, two upper address bits, then direction bit.
// [RULE3] Second address byte carries the lower eight address bits.
// [RULE4] Ack first byte of a write when its upper bits match any enabled own address.
// [RULE5] Ack second byte only when all ten bits match one single address.
// [RULE6] Take data bytes only after a complete matching address.
// [RULE7] Own addresses may differ in upper bits; matching stays exact anyway.
// [RULE8] Mismatching byte gets a released data line and rest is ignored.
`include "itam_regs.svh"
module itam_top
    import itam_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic tgt_en,
    input wire logic [3:0] own_en,
    input wire logic [9:0] own_addr_0,
    input wire logic [9:0] own_addr_1,
    input wire logic [9:0] own_addr_2,
    input wire logic [9:0] own_addr_3,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic [1:0] match_sel,
    output logic addressed
);
    logic scl_s1_r;
    logic scl_s2_r;
    logic scl_d_r;
    logic sda_s1_r;
    logic sda_s2_r;
    logic sda_d_r;
    logic start_det;
    logic stop_det;
    logic scl_rise;
    logic scl_fall;
    logic [3:0] hi_hits;
    logic [3:0] full_hits;
    itam_state_e state_r;
    itam_state_e state_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] shreg_r;
    logic [7:0] shreg_nxt;
    logic [1:0] hi_r;
    logic [1:0] hi_nxt;
    logic sda_oe_r;
    logic sda_oe_nxt;
    logic [7:0] rx_data_r;
    logic [7:0] rx_data_nxt;
    logic rx_valid_r;
    logic rx_valid_nxt;
    logic [1:0] sel_r;
    logic [1:0] sel_nxt;
    logic addressed_r;
    logic addressed_nxt;
    logic sda_o_r;

    // Per-address compare; the four results are kept apart so an upper
    // part of one address never combines with the lower part of another
    function automatic logic [3:0] hit_mask(input logic [9:0] a,
                                            input logic [9:0] mask);
        logic [9:0] own [4];
        logic [3:0] m;
        own[0] = own_addr_0;
        own[1] = own_addr_1;
        own[2] = own_addr_2;
        own[3] = own_addr_3;
        m = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            m[i] = own_en[i] && ((own[i] & mask) == (a & mask)); // RULE1
        end
        return m;
    endfunction

    function automatic logic [1:0] first_hit(input logic [3:0] m);
        logic [1:0] s;
        s = 2'h0;
        for (int i = 3; i >= 0; i--)
        begin
            if (m[i])
            begin
                s = 2'(i);
            end
        end
        return s;
    endfunction

    // Bus lines are asynchronous to core_clk: two flops before any use
    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            scl_s1_r <= 1'b1;
            scl_s2_r <= 1'b1;
            scl_d_r <= 1'b1;
            sda_s1_r <= 1'b1;
            sda_s2_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            scl_s1_r <= scl_i;
            scl_s2_r <= scl_s1_r;
            scl_d_r <= scl_s2_r;
            sda_s1_r <= sda_i;
            sda_s2_r <= sda_s1_r;
            sda_d_r <= sda_s2_r;
        end
    end

    assign start_det = scl_s2_r && sda_d_r && !sda_s2_r;
    assign stop_det = scl_s2_r && !sda_d_r && sda_s2_r;
    assign scl_rise = scl_s2_r && !scl_d_r;
    assign scl_fall = !scl_s2_r && scl_d_r;
    // Only the two upper bits take part in the first-byte compare;
    // always_comb also wakes on the own addresses read inside hit_mask
    always_comb
    begin
        hi_hits = hit_mask({shreg_r[2:1], `ITAM_BYTE_ZERO},
                           `ITAM_HI_MASK); // RULE4 RULE7
        full_hits = hit_mask({hi_r, shreg_r}, `ITAM_FULL_MASK); // RULE3 RULE5
    end

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shreg_nxt = shreg_r;
        hi_nxt = hi_r;
        sda_oe_nxt = sda_oe_r;
        rx_data_nxt = rx_data_r;
        rx_valid_nxt = 1'b0;
        sel_nxt = sel_r;
        addressed_nxt = addressed_r;
        if (start_det)
        begin
            state_nxt = tgt_en ? ITAM_ADDR1 : ITAM_IGNORE;
            cnt_nxt = `ITAM_CNT_ZERO;
            sda_oe_nxt = 1'b0;
            addressed_nxt = 1'b0;
        end
        else if (stop_det)
        begin
            state_nxt = ITAM_IDLE;
            sda_oe_nxt = 1'b0;
            addressed_nxt = 1'b0;
        end
        else
        begin
            unique case (state_r)
                ITAM_IDLE, ITAM_IGNORE:
                begin
                    sda_oe_nxt = 1'b0; // RULE8
                end
                ITAM_ADDR1, ITAM_ADDR2, ITAM_DATA:
                begin
                    if (scl_rise)
                    begin
                        shreg_nxt = {shreg_r[6:0], sda_s2_r};
                        cnt_nxt = cnt_r + `ITAM_CNT_ONE;
                    end
                    else if (scl_fall && cnt_r == `ITAM_BYTE_BITS)
                    begin
                        cnt_nxt = `ITAM_CNT_ZERO;
                        state_nxt = ITAM_IGNORE; // RULE8
                        if (state_r == ITAM_ADDR1)
                        begin
                            // Read direction has no transmit path: refused
                            if (shreg_r[7:3] == `ITAM_PREFIX && !shreg_r[0]
                                && |hi_hits) // RULE2 RULE4
                            begin
                                hi_nxt = shreg_r[2:1];
                                sda_oe_nxt = 1'b1;
                                state_nxt = ITAM_ACK1;
                            end
                        end
                        else if (state_r == ITAM_ADDR2)
                        begin
                            if (|full_hits) // RULE5
                            begin
                                sel_nxt = first_hit(full_hits);
                                sda_oe_nxt = 1'b1;
                                addressed_nxt = 1'b1;
                                state_nxt = ITAM_ACK2;
                            end
                        end
                        else
                        begin
                            rx_data_nxt = shreg_r; // RULE6
                            rx_valid_nxt = 1'b1;
                            sda_oe_nxt = 1'b1;
                            state_nxt = ITAM_DACK;
                        end
                    end
                end
                ITAM_ACK1, ITAM_ACK2, ITAM_DACK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_nxt = 1'b0;
                        state_nxt = (state_r == ITAM_ACK1) ? ITAM_ADDR2
                                                           : ITAM_DATA; // RULE6
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= ITAM_IDLE;
            cnt_r <= `ITAM_CNT_ZERO;
            shreg_r <= `ITAM_BYTE_ZERO;
            hi_r <= `ITAM_HI_ZERO;
            sda_oe_r <= 1'b0;
            rx_data_r <= `ITAM_BYTE_ZERO;
            rx_valid_r <= 1'b0;
            sel_r <= `ITAM_SEL_ZERO;
            addressed_r <= 1'b0;
            sda_o_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            shreg_r <= shreg_nxt;
            hi_r <= hi_nxt;
            sda_oe_r <= sda_oe_nxt;
            rx_data_r <= rx_data_nxt;
            rx_valid_r <= rx_valid_nxt;
            sel_r <= sel_nxt;
            addressed_r <= addressed_nxt;
            sda_o_r <= 1'b0;
        end
    end

    assign sda_o = sda_o_r;
    assign sda_oe = sda_oe_r;
    assign rx_data = rx_data_r;
    assign rx_valid = rx_valid_r;
    assign match_sel = sel_r;
    assign addressed = addressed_r;
endmodule

/* verification/itam_checker.sv */
// Port-level assertions of the ten-bit multi-address target matcher
module itam_checker
    import itam_pkg::*;
(
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic [3:0] own_en,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    input wire logic [7:0] rx_data,
    input wire logic rx_valid,
    input wire logic [1:0] match_sel,
    input wire logic addressed
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    chk_ack_low: assert property (sda_oe |-> !sda_o)
        else $error("ack does not pull the line low");
    chk_valid_addr: assert property (rx_valid |-> addressed && sda_oe)
        else $error("data taken without a matched address");
    chk_valid_pulse: assert property (rx_valid |=> !rx_valid)
        else $error("data strobe longer than one cycle");
    chk_rx_cause: assert property ($changed(rx_data) |-> rx_valid)
        else $error("received byte changed without a strobe");
    chk_sel_enabled: assert property ($rose(addressed) |->
        sda_oe && own_en[match_sel])
        else $error("address accepted for a disabled slot");
    chk_ack_scl_low: assert property ($rose(sda_oe) |-> !scl_i)
        else $error("ack started while clock high");
    chk_ack_ends: assert property ($rose(sda_oe) |-> ##[4:60] !sda_oe)
        else $error("ack not released after its clock");
    chk_stop_clears: assert property (addressed && scl_i && $rose(sda_i)
        |-> ##[1:6] !addressed)
        else $error("stop did not end the addressed phase");
endmodule
bind itam_top itam_checker u_chk (.core_clk(core_clk), .arst_n(arst_n),
    .own_en(own_en), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
    .sda_oe(sda_oe), .rx_data(rx_data), .rx_valid(rx_valid),
    .match_sel(match_sel), .addressed(addressed));

/* verification/itam_ctl_model.sv */
// Behavioural I2C bus controller that addresses the target
module itam_ctl_model (
    input wire logic core_clk,
    input wire logic sda_w,
    output logic scl,
    output logic sda_m
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    // Driving 1 stands for the pull-up, so a released line reads high
    task automatic bit_io(input logic b, output logic s);
        sda_m <= b;
        w(6);
        scl <= 1'b1;
        w(4);
        s = sda_w;
        w(4);
        scl <= 1'b0;
    endtask
    task automatic start();
        scl <= 1'b1;
        w(8);
        sda_m <= 1'b0;
        w(8);
        scl <= 1'b0;
        w(6);
    endtask
    task automatic put(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], s);
        bit_io(1'b1, s);
        ack = !s;
        w(6);
    endtask
    task automatic stop();
        sda_m <= 1'b0;
        w(6);
        scl <= 1'b1;
        w(8);
        sda_m <= 1'b1;
        w(8);
    endtask
endmodule

/* verification/testbench.sv */
// Self-checking bench of the ten-bit multi-address target matcher
`include "itam_regs.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import itam_pkg::*;
    logic core_clk, arst_n, tgt_en, scl, sda_m, sda_w, sda_o, sda_oe;
    logic rx_valid, addressed, k1, k2;
    logic [3:0] own_en;
    logic [9:0] own_addr [4];
    logic [7:0] rx_data, rx_last;
    logic [1:0] match_sel;
    int err_count, checks, rx_cnt, cyc;
    // Open-drain wire: the target can only pull low
    assign sda_w = sda_m & ~(sda_oe & ~sda_o);
    itam_top u_dut (.core_clk(core_clk), .arst_n(arst_n), .tgt_en(tgt_en),
        .own_en(own_en), .own_addr_0(own_addr[0]), .own_addr_1(own_addr[1]),
        .own_addr_2(own_addr[2]), .own_addr_3(own_addr[3]), .scl_i(scl),
        .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .rx_data(rx_data),
        .rx_valid(rx_valid), .match_sel(match_sel), .addressed(addressed));
    itam_ctl_model u_ctl (.core_clk(core_clk), .sda_w(sda_w), .scl(scl),
        .sda_m(sda_m));
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic end_of_test();
        if (err_count == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Second byte is always sent, so a refused first byte must stay ignored
    task automatic addr10(input logic [9:0] a, input logic rd);
        u_ctl.start();
        u_ctl.put({`ITAM_PREFIX, a[9:8], rd}, k1);
        u_ctl.put(a[7:0], k2);
    endtask
    task automatic t_match();
        for (int i = 0; i < 4; i++)
        begin
            addr10(own_addr[i], 1'b0);
            chk(k1, 10'h1);
            chk(k2, 10'h1);
            chk(match_sel, 10'(i));
            chk(addressed, 10'h1);
            u_ctl.put(8'h5a + 8'(i), k1);
            chk(k1, 10'h1);
            chk(rx_last, 10'h5a + 10'(i));
            u_ctl.stop();
            chk(addressed, 10'h0);
        end
    endtask
    // Upper bits of one slot with lower bits of another
    task automatic t_mixed();
        int n;
        addr10({own_addr[1][9:8], own_addr[0][7:0]}, 1'b0);
        chk(k1, 10'h1);
        chk(k2, 10'h0);
        chk(addressed, 10'h0);
        n = rx_cnt;
        u_ctl.put(8'h33, k1);
        chk(k1, 10'h0);
        chk(10'(rx_cnt), 10'(n));
        u_ctl.stop();
    endtask
    // Wrong prefix with otherwise valid upper bits is refused
    task automatic t_prefix();
        u_ctl.start();
        u_ctl.put({5'h1c, own_addr[3][9:8], 1'b0}, k1);
        u_ctl.put(own_addr[3][7:0], k2);
        chk(k1, 10'h0);
        chk(k2, 10'h0);
        chk(addressed, 10'h0);
        u_ctl.stop();
    endtask
    task automatic t_nack(input logic [9:0] a, input logic rd,
        input logic [3:0] en, input logic ten);
        own_en <= en;
        tgt_en <= ten;
        addr10(a, rd);
        chk(k1, 10'h0);
        chk(k2, 10'h0);
        chk(addressed, 10'h0);
        u_ctl.stop();
        own_en <= 4'hf;
        tgt_en <= 1'b1;
    endtask
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (rx_valid === 1'b1)
        begin
            rx_last <= rx_data;
            rx_cnt <= rx_cnt + 1;
        end
        if (cyc == 40000)
        begin
            err_count++;
            end_of_test();
        end
    end
    initial
    begin
        arst_n = 1'b0;
        tgt_en = 1'b0;
        own_en = 4'h0;
        own_addr = '{10'h2a5, 10'h0c3, 10'h1f0, 10'h3a5};
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        tgt_en <= 1'b1;
        own_en <= 4'hf;
        repeat (4) @(posedge core_clk);
        t_match();
        t_mixed();
        t_prefix();
        t_nack(own_addr[1], 1'b0, 4'hd, 1'b1);
        t_nack(own_addr[0], 1'b1, 4'hf, 1'b1);
        t_nack(own_addr[2], 1'b0, 4'hf, 1'b0);
        end_of_test();
    end
endmodule
